/* File: hw/tmc_pkg.sv */
// constants for the 16-bit match/capture/pwm timer
package tmc_pkg;
   localparam int unsigned NUM_MATCH = 4;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned FLAG_W = 5;
   // byte offsets on the register bus
   localparam logic [7:0] OFS_RUN_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_PRESCALE = 8'h08;
   localparam logic [7:0] OFS_PRESCALE_CNT = 8'h0c;
   localparam logic [7:0] OFS_MATCH_CTRL = 8'h14;
   localparam logic [7:0] OFS_MATCH0 = 8'h18;
   localparam logic [7:0] OFS_MATCH1 = 8'h1c;
   localparam logic [7:0] OFS_MATCH2 = 8'h20;
   localparam logic [7:0] OFS_MATCH3 = 8'h24;
   localparam logic [7:0] OFS_CAP_CTRL = 8'h28;
   localparam logic [7:0] OFS_CAP_VALUE = 8'h2c;
   localparam logic [7:0] OFS_OUT_MATCH = 8'h30;
   localparam logic [7:0] OFS_PULSE_CTRL = 8'h34;
   localparam logic [7:0] OFS_RAW_FLAGS = 8'h38;
   localparam logic [7:0] OFS_FLAG_CLEAR = 8'h3c;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;
   // field positions
   localparam int unsigned RUN_EN_BIT = 0;
   localparam int unsigned CNT_RST_BIT = 1;
   localparam int unsigned MCH_STRIDE = 3;
   localparam int unsigned MCH_IRQ_OFS = 0;
   localparam int unsigned MCH_CLR_OFS = 1;
   localparam int unsigned MCH_HALT_OFS = 2;
   localparam int unsigned MCTRL_W = 12;
   localparam int unsigned CAP_RISE_LSB = 0;
   localparam int unsigned CAP_FALL_LSB = 2;
   localparam int unsigned CAP_IRQ_BIT = 4;
   localparam int unsigned CAP_FUNC_LSB = 5;
   localparam int unsigned EXT_STATE_BIT = 0;
   localparam int unsigned OUT_ACTION_LSB = 4;
   localparam int unsigned PULSE_MODE_BIT = 0;
   localparam int unsigned PIN_SEL_BIT = 20;
   localparam int unsigned CAP_FLAG_BIT = 4;
   // reset values
   localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [MCTRL_W-1:0] RST_MCTRL = 12'h000;
   localparam logic [FLAG_W-1:0] RST_FLAGS = 5'h00;
   localparam logic [1:0] RST_FIELD2 = 2'h0;
   localparam logic RST_BIT = 1'b0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // encodings
   localparam logic [1:0] CAP_FUNC_ON = 2'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {
      CAP_NONE = 2'h0,
      CAP_LOAD = 2'h1,
      CAP_CLEAR = 2'h2,
      CAP_RSVD = 2'h3
   } tmc_cap_act_e;
   typedef enum logic [1:0] {
      OUT_KEEP = 2'h0,
      OUT_LOW = 2'h1,
      OUT_HIGH = 2'h2,
      OUT_TOGGLE = 2'h3
   } tmc_out_act_e;
endpackage

/* File: hw/tmc_edge_if.sv */
// edge events of the capture pin, passed between the timer modules
`timescale 1ns/10ps
`default_nettype none
interface tmc_edge_if;
   logic rise;
   logic fall;
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface
`default_nettype wire

/* File: hw/tmc_edge_detect.sv */
// capture pin synchroniser and edge detector
`timescale 1ns/10ps
`default_nettype none
module tmc_edge_detect (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // pin and events
   input wire logic pin_i,
   tmc_edge_if.src edge_o
);
   import tmc_pkg::*;
   logic sync_a;
   logic sync_b;
   logic prev;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_a <= RST_BIT;
         sync_b <= RST_BIT;
         prev <= RST_BIT;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   assign edge_o.rise = sync_b & ~prev;
   assign edge_o.fall = ~sync_b & prev;
endmodule
`default_nettype wire

/* File: hw/tmc_timer16.sv */
// 16-bit timer with four match channels, one capture input and one match/pwm pin
//
// Summary of operation
// R1: halt-enabled match stops timer and prescale counts and clears run enable.
// R2: reset-enabled match returns the timer count to zero.
// R3: interrupt-enabled match raises that channel's raw flag.
// R4: four 16-bit match values at 0x18..0x24 compared with the count continuously.
// R5: rise and fall actions may both be enabled; each edge then acts.
// R6: capture function field: 1 enables the pin, others off; drives pin function.
// R7: with capture interrupt enabled, each pin-caused load sets the capture flag.
// R8: falling edge field: 0 none, 1 load capture, 2 zero count, 3 reserved.
// R9: rising edge field: 0 none, 1 load capture, 2 zero count, 3 reserved.
// R10: capture value is read-only, resets to zero, changes only on loads.
// R11: output action field on match 0: keep, low, high, toggle.
// R12: match 0 updates the external match bit, which drives the output.
// R13: in pulse mode the output follows pulse logic, not the action field.
// R14: software sets a cycle-length reset match; match 0 drives the output high.
// R15: when the count returns to zero, a high pulse output is cleared; the code leaves it high while match 0 is zero.
// R16: pin select 0 leaves the pin to gpio; 1 makes it the match output.
// R17: pulse mode bit 0 follows external match bit; 1 selects pulse output.
// R18: raw flags: bit 4 capture, bits 3..0 match channels, read-only.
// R19: a raw flag reaches the interrupt line only while its enable is set.
// R20: writing one to the clear register clears that flag; zero does nothing.
// R21: match 3 with halt enabled stops both counters and clears run enable.
// R22: software zeroes capture control whenever edge counting mode is chosen.
// R23: a flag set and its clear in one cycle leave the flag set.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer16 (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // pins
   input wire logic capture_input_pin_i,
   output logic match_output_pin_o,
   output logic match_pin_func_o,
   output logic capture_pin_func_o,
   // interrupt request
   output logic irq_o
);
   import tmc_pkg::*;

   // bus phase state
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_take;
   logic [31:0] next_rdata;

   // registers
   logic run_enable;
   logic cnt_reset_req;
   logic [CNT_W-1:0] timer_count;
   logic [CNT_W-1:0] prescale_max;
   logic [CNT_W-1:0] prescale_count;
   logic [MCTRL_W-1:0] match_ctrl;
   logic [CNT_W-1:0] match_value [NUM_MATCH];
   logic [1:0] capture_func_en;
   logic capture_irq_en;
   logic [1:0] capture_fall_action;
   logic [1:0] capture_rise_action;
   logic [CNT_W-1:0] capture_value;
   logic [1:0] match_out_action;
   logic ext_match_state;
   logic out_pin_select;
   logic pulse_mode_enable;
   logic [FLAG_W-1:0] raw_flags;
   logic [FLAG_W-1:0] irq_enable_reg;
   logic pulse_state;
   logic count_zeroed_d;
   // derived events
   logic tick;
   logic [NUM_MATCH-1:0] match_evt;
   logic [NUM_MATCH-1:0] match_irq_en;
   logic [NUM_MATCH-1:0] match_clear_en;
   logic [NUM_MATCH-1:0] match_halt_en;
   logic clear_hit;
   logic halt_hit;
   logic cap_on;
   logic cap_load;
   logic cap_clear;
   logic count_zeroed;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;
   logic [1:0] rise_act;
   logic [1:0] fall_act;
   tmc_edge_if cap_edge ();
   tmc_edge_detect u_edge (
      .core_clk_i (core_clk_i),
      .rstn_i (rstn_i),
      .pin_i (capture_input_pin_i),
      .edge_o (cap_edge)
   );

   assign addr_take = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_pend <= RST_BIT;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_take & hwrite_i;
         wr_addr <= haddr_i[7:0];
      end
   end
   // zero wait states, always okay
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= RST_BIT;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= RST_BIT;
      end
   end
   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = wr_pend && (wr_addr == ofs);
   endfunction
   // read data sampled in the address phase, unmapped reads zero
   always_comb begin
      next_rdata = RST_WORD;
      case (haddr_i[7:0])
         OFS_RUN_CTRL: begin
            next_rdata[RUN_EN_BIT] = run_enable;
            next_rdata[CNT_RST_BIT] = cnt_reset_req;
         end
         OFS_COUNT: next_rdata[CNT_W-1:0] = timer_count;
         OFS_PRESCALE: next_rdata[CNT_W-1:0] = prescale_max;
         OFS_PRESCALE_CNT: next_rdata[CNT_W-1:0] = prescale_count;
         OFS_MATCH_CTRL: next_rdata[MCTRL_W-1:0] = match_ctrl;
         OFS_MATCH0: next_rdata[CNT_W-1:0] = match_value[0];
         OFS_MATCH1: next_rdata[CNT_W-1:0] = match_value[1];
         OFS_MATCH2: next_rdata[CNT_W-1:0] = match_value[2];
         OFS_MATCH3: next_rdata[CNT_W-1:0] = match_value[3];
         OFS_CAP_CTRL: begin
            next_rdata[CAP_FUNC_LSB +: 2] = capture_func_en;
            next_rdata[CAP_IRQ_BIT] = capture_irq_en;
            next_rdata[CAP_FALL_LSB +: 2] = capture_fall_action;
            next_rdata[CAP_RISE_LSB +: 2] = capture_rise_action;
         end
         OFS_CAP_VALUE: next_rdata[CNT_W-1:0] = capture_value; // R10
         OFS_OUT_MATCH: begin
            next_rdata[OUT_ACTION_LSB +: 2] = match_out_action;
            next_rdata[EXT_STATE_BIT] = ext_match_state;
         end
         OFS_PULSE_CTRL: begin
            next_rdata[PIN_SEL_BIT] = out_pin_select;
            next_rdata[PULSE_MODE_BIT] = pulse_mode_enable;
         end
         OFS_RAW_FLAGS: next_rdata[FLAG_W-1:0] = raw_flags; // R18
         OFS_IRQ_ENABLE: next_rdata[FLAG_W-1:0] = irq_enable_reg;
         default: next_rdata = RST_WORD;
      endcase
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hrdata_o <= RST_WORD;
      end else if (addr_take && !hwrite_i) begin
         hrdata_o <= next_rdata;
      end
   end

   assign tick = run_enable & ~cnt_reset_req & (prescale_count == prescale_max);
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MATCH; gi++) begin : g_match
         assign match_irq_en[gi] = match_ctrl[gi*MCH_STRIDE + MCH_IRQ_OFS];
         assign match_clear_en[gi] = match_ctrl[gi*MCH_STRIDE + MCH_CLR_OFS];
         assign match_halt_en[gi] = match_ctrl[gi*MCH_STRIDE + MCH_HALT_OFS];
         assign match_evt[gi] = tick & (match_value[gi] == timer_count); // R4
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               match_value[gi] <= RST_COUNT;
            end else if (wr_hit(OFS_MATCH0 + 8'(gi * 4))) begin
               match_value[gi] <= hwdata_i[CNT_W-1:0]; // R4
            end
         end
      end
   endgenerate
   assign clear_hit = |(match_evt & match_clear_en); // R2 R14
   assign halt_hit = |(match_evt & match_halt_en); // R1 R21

   assign cap_on = (capture_func_en == CAP_FUNC_ON); // R6
   assign rise_act = (cap_on & cap_edge.rise) ? capture_rise_action : CAP_NONE; // R9 R5
   assign fall_act = (cap_on & cap_edge.fall) ? capture_fall_action : CAP_NONE; // R8 R5
   assign cap_load = (rise_act == CAP_LOAD) | (fall_act == CAP_LOAD);
   assign cap_clear = (rise_act == CAP_CLEAR) | (fall_act == CAP_CLEAR);
   assign count_zeroed = cnt_reset_req | cap_clear | (tick & clear_hit);

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         run_enable <= RST_BIT;
      end else if (halt_hit) begin
         run_enable <= 1'b0; // R1 R21
      end else if (wr_hit(OFS_RUN_CTRL)) begin
         run_enable <= hwdata_i[RUN_EN_BIT];
      end
   end
   // one-shot synchronous counter reset, cleared by hardware
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reset_req <= RST_BIT;
      end else begin
         cnt_reset_req <= wr_hit(OFS_RUN_CTRL) & hwdata_i[CNT_RST_BIT];
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prescale_max <= RST_COUNT;
         match_ctrl <= RST_MCTRL;
      end else begin
         if (wr_hit(OFS_PRESCALE)) begin
            prescale_max <= hwdata_i[CNT_W-1:0];
         end
         if (wr_hit(OFS_MATCH_CTRL)) begin
            match_ctrl <= hwdata_i[MCTRL_W-1:0];
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         capture_func_en <= RST_FIELD2;
         capture_irq_en <= RST_BIT;
         capture_fall_action <= RST_FIELD2;
         capture_rise_action <= RST_FIELD2;
      end else if (wr_hit(OFS_CAP_CTRL)) begin
         capture_func_en <= hwdata_i[CAP_FUNC_LSB +: 2]; // R6
         capture_irq_en <= hwdata_i[CAP_IRQ_BIT];
         capture_fall_action <= hwdata_i[CAP_FALL_LSB +: 2]; // R8
         capture_rise_action <= hwdata_i[CAP_RISE_LSB +: 2]; // R9
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_pin_select <= RST_BIT;
         pulse_mode_enable <= RST_BIT;
         irq_enable_reg <= RST_FLAGS;
      end else begin
         if (wr_hit(OFS_PULSE_CTRL)) begin
            out_pin_select <= hwdata_i[PIN_SEL_BIT];
            pulse_mode_enable <= hwdata_i[PULSE_MODE_BIT];
         end
         if (wr_hit(OFS_IRQ_ENABLE)) begin
            irq_enable_reg <= hwdata_i[FLAG_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prescale_count <= RST_COUNT;
      end else if (cnt_reset_req || cap_clear) begin
         prescale_count <= RST_COUNT;
      end else if (wr_hit(OFS_PRESCALE_CNT)) begin
         prescale_count <= hwdata_i[CNT_W-1:0];
      end else if (halt_hit) begin
         prescale_count <= prescale_count; // R1 R21
      end else if (tick) begin
         prescale_count <= RST_COUNT;
      end else if (run_enable) begin
         prescale_count <= prescale_count + 16'h0001;
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_count <= RST_COUNT;
      end else if (count_zeroed) begin
         timer_count <= RST_COUNT; // R2 R8 R9
      end else if (wr_hit(OFS_COUNT)) begin
         timer_count <= hwdata_i[CNT_W-1:0];
      end else if (halt_hit) begin
         timer_count <= timer_count; // R1 R21
      end else if (tick) begin
         timer_count <= timer_count + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         capture_value <= RST_COUNT;
      end else if (cap_load) begin
         capture_value <= timer_count; // R10
      end
   end

   assign flag_set[NUM_MATCH-1:0] = match_evt & match_irq_en; // R3
   assign flag_set[CAP_FLAG_BIT] = cap_load & capture_irq_en; // R7
   assign flag_clr = wr_hit(OFS_FLAG_CLEAR) ? hwdata_i[FLAG_W-1:0] : RST_FLAGS; // R20
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         raw_flags <= RST_FLAGS;
      end else begin
         raw_flags <= (raw_flags & ~flag_clr) | flag_set; // R23
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= RST_BIT;
      end else begin
         irq_o <= |(raw_flags & irq_enable_reg); // R19
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_out_action <= OUT_KEEP;
         ext_match_state <= RST_BIT;
      end else begin
         if (wr_hit(OFS_OUT_MATCH)) begin
            match_out_action <= hwdata_i[OUT_ACTION_LSB +: 2];
         end
         if (match_evt[0] && !pulse_mode_enable) begin // R13
            case (tmc_out_act_e'(match_out_action)) // R11 R12
               OUT_KEEP: ext_match_state <= ext_match_state;
               OUT_LOW: ext_match_state <= 1'b0;
               OUT_HIGH: ext_match_state <= 1'b1;
               OUT_TOGGLE: ext_match_state <= ~ext_match_state;
               default: ext_match_state <= ext_match_state;
            endcase
         end else if (wr_hit(OFS_OUT_MATCH)) begin
            ext_match_state <= hwdata_i[EXT_STATE_BIT];
         end
      end
   end

   // clear lands one cycle after the count is zeroed, so a duty
   // equal to the cycle length still gives a one-cycle pulse
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_zeroed_d <= RST_BIT;
      end else begin
         count_zeroed_d <= count_zeroed;
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pulse_state <= RST_BIT;
      end else if (match_evt[0]) begin
         pulse_state <= 1'b1; // R14
      end else if (count_zeroed_d && match_value[0] != RST_COUNT) begin
         pulse_state <= 1'b0; // R15
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_output_pin_o <= RST_BIT;
         match_pin_func_o <= RST_BIT;
         capture_pin_func_o <= RST_BIT;
      end else begin
         match_output_pin_o <= pulse_mode_enable ? pulse_state : ext_match_state; // R17 R13
         match_pin_func_o <= out_pin_select; // R16
         capture_pin_func_o <= cap_on; // R6
      end
   end
endmodule
`default_nettype wire

/* File: tb/tmc_pin_partner.sv */
// pin-side partner: capture pin driver and match pin high-time counter
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_partner (
   // clock
   input wire logic core_clk_i,
   // control from the bench
   input wire logic level_i,
   input wire logic meas_i,
   // pins
   input wire logic pin_out_i,
   output logic cap_pin_o,
   output logic [15:0] high_cnt_o
);
   // pin changes just after a clock edge
   always_ff @(posedge core_clk_i) begin
      cap_pin_o <= level_i;
      if (!meas_i) begin
         high_cnt_o <= 16'h0;
      end else if (pin_out_i) begin
         high_cnt_o <= high_cnt_o + 16'h1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tmc_timer16_properties.sv */
// port-level properties of the 16-bit match/capture/pwm timer
`timescale 1ns/10ps
`default_nettype none
module tmc_timer16_properties (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   // pins
   input wire logic capture_input_pin_i,
   input wire logic match_output_pin_o,
   input wire logic match_pin_func_o,
   input wire logic capture_pin_func_o,
   input wire logic irq_o
);
   import tmc_pkg::*;
   logic ap_w, run_sh, pm_sh, rd_ap;
   logic [7:0] ap_a;
   logic [4:0] ie_sh;
   assign rd_ap = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i;
   // write address phase, for its data phase
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ap_w <= 1'b0;
         ap_a <= 8'h00;
      end else begin
         ap_w <= hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hwrite_i;
         ap_a <= haddr_i[7:0];
      end
   end
   // shadows of written control bits
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         run_sh <= 1'b0;
         pm_sh <= 1'b0;
         ie_sh <= 5'h00;
      end else if (ap_w) begin
         case (ap_a)
            OFS_RUN_CTRL: run_sh <= hwdata_i[RUN_EN_BIT];
            OFS_PULSE_CTRL: pm_sh <= hwdata_i[PULSE_MODE_BIT];
            OFS_IRQ_ENABLE: ie_sh <= hwdata_i[4:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus slave stalled or flagged an error");
   a_pin_select: assert property (ap_w && ap_a == OFS_PULSE_CTRL |-> ##2
      match_pin_func_o == $past(hwdata_i[PIN_SEL_BIT], 2)) else $error("pin select wrong");
   a_cap_func: assert property (ap_w && ap_a == OFS_CAP_CTRL |-> ##2
      capture_pin_func_o == ($past(hwdata_i[6:5], 2) == CAP_FUNC_ON))
      else $error("capture pin function wrong");
   a_ext_drive: assert property (ap_w && ap_a == OFS_OUT_MATCH && !run_sh && !pm_sh |-> ##2
      match_output_pin_o == $past(hwdata_i[EXT_STATE_BIT], 2)) else $error("ext bit not on pin");
   a_irq_masked: assert property ($past(ie_sh) == 5'h00 |-> !irq_o)
      else $error("interrupt raised while masked");
   a_flags_width: assert property (rd_ap && haddr_i[7:0] == OFS_RAW_FLAGS |=>
      hrdata_o[31:5] == 27'h0) else $error("raw flag upper bits set");
   a_clear_wo: assert property (rd_ap && haddr_i[7:0] == OFS_FLAG_CLEAR |=>
      hrdata_o == 32'h0) else $error("clear register reads nonzero");
   a_cap_width: assert property (rd_ap && haddr_i[7:0] == OFS_CAP_VALUE |=>
      hrdata_o[31:16] == 16'h0) else $error("capture value too wide");
   a_match_width: assert property (rd_ap && haddr_i[7:0] inside {[OFS_MATCH0:OFS_MATCH3]} |=>
      hrdata_o[31:16] == 16'h0) else $error("match value too wide");
endmodule
bind tmc_timer16 tmc_timer16_properties u_props (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .hrdata_o(hrdata_o), .capture_input_pin_i(capture_input_pin_i),
   .match_output_pin_o(match_output_pin_o), .match_pin_func_o(match_pin_func_o),
   .capture_pin_func_o(capture_pin_func_o), .irq_o(irq_o));
`default_nettype wire

/* File: tb/timer16_match_capture_pwm_bench.sv */
// self-checking bench for the 16-bit match/capture/pwm timer
`timescale 1ns/10ps
`default_nettype none
module timer16_match_capture_pwm_bench;
   import tmc_pkg::*;
   logic clk, rstn, hsel, hwrite, level, meas, rdy, resp, pin_o, pin_fn, cap_fn, irq, cap_pin;
   logic b, ld, clr, fon;
   logic [1:0] htrans, act;
   logic [31:0] haddr, hwdata, hrdata, rd, cc;
   logic [15:0] hi_cnt, c, v, d, p;
   int err_count = 0;
   int cmp_count = 0;
   tmc_timer16 dut (.core_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
      .hreadyout_o(rdy), .hresp_o(resp), .hrdata_o(hrdata), .capture_input_pin_i(cap_pin),
      .match_output_pin_o(pin_o), .match_pin_func_o(pin_fn), .capture_pin_func_o(cap_fn),
      .irq_o(irq));
   tmc_pin_partner peer (.core_clk_i(clk), .level_i(level), .meas_i(meas), .pin_out_i(pin_o),
      .cap_pin_o(cap_pin), .high_cnt_o(hi_cnt));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // address phase until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_halt;
      int n = 0;
      do begin
         xfer(1'b0, OFS_RUN_CTRL, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 60);
   endtask
   function automatic logic exp_ext(input logic [1:0] a, input logic init);
      return a[0] ? (a[1] ? ~init : 1'b0) : (a[1] ? 1'b1 : init);
   endfunction
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      err_count++;
      final_report;
   end
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      level = 1'b0;
      meas = 1'b0;
      void'($urandom(32'hfff7));
      wt(8);
      rstn <= 1'b1;
      wt(1);
      for (int a = 24; a <= 60; a += 4) begin
         rc(8'(a), 32'h0);
      end
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         xfer(1'b1, OFS_MATCH0 + 8'(4 * i), {16'($urandom), v});
         rc(OFS_MATCH0 + 8'(4 * i), {16'h0, v});
      end
      xfer(1'b1, OFS_CAP_VALUE, $urandom);
      rc(OFS_CAP_VALUE, 32'h0);
      xfer(1'b1, OFS_RAW_FLAGS, 32'h1f);
      rc(OFS_RAW_FLAGS, 32'h0);
      $display("test registers done");
      for (int ch = 0; ch < 4; ch++) begin
         v = 16'($urandom_range(20, 4));
         xfer(1'b1, OFS_MATCH0 + 8'(4 * ch), {16'h0, v});
         xfer(1'b1, OFS_COUNT, 32'h0);
         xfer(1'b1, OFS_MATCH_CTRL, 32'h5 << (3 * ch));
         xfer(1'b1, OFS_FLAG_CLEAR, 32'h1f);
         xfer(1'b1, OFS_RUN_CTRL, 32'h1);
         wait_halt;
         chk(rd, 32'h0);
         rc(OFS_COUNT, {16'h0, v});
         rc(OFS_RAW_FLAGS, 32'h1 << ch);
      end
      chk(irq, 1'b0);
      xfer(1'b1, OFS_IRQ_ENABLE, 32'h8);
      wt(2);
      chk(irq, 1'b1);
      xfer(1'b1, OFS_FLAG_CLEAR, 32'h17);
      rc(OFS_RAW_FLAGS, 32'h8);
      xfer(1'b1, OFS_FLAG_CLEAR, 32'h8);
      rc(OFS_RAW_FLAGS, 32'h0);
      $display("test halt done");
      v = 16'($urandom_range(9, 3));
      xfer(1'b1, OFS_MATCH0, {16'h0, v});
      xfer(1'b1, OFS_MATCH_CTRL, 32'h3);
      xfer(1'b1, OFS_COUNT, 32'h0);
      xfer(1'b1, OFS_RUN_CTRL, 32'h1);
      wt(40);
      xfer(1'b1, OFS_RUN_CTRL, 32'h0);
      xfer(1'b0, OFS_COUNT, 32'h0);
      chk({31'h0, rd[15:0] <= v}, 32'h1);
      rc(OFS_RAW_FLAGS, 32'h1);
      $display("test reset match done");
      xfer(1'b1, OFS_MATCH_CTRL, 32'h0);
      xfer(1'b1, OFS_IRQ_ENABLE, 32'h10);
      v = 16'h0;
      // even k rise, odd k fall; 8..9 func off, 10..11 both edges
      for (int k = 0; k < 12; k++) begin
         c = 16'($urandom_range(65000, 1));
         fon = k < 8 || k > 9;
         act = (k < 8) ? 2'(k >> 1) : 2'h1;
         cc = {25'h0, fon ? 2'h1 : 2'h2, 1'b1, (k[0] || k > 7) ? act : 2'h0,
            (!k[0] || k > 7) ? act : 2'h0};
         ld = fon && act == CAP_LOAD;
         clr = fon && act == CAP_CLEAR;
         v = ld ? c : v;
         xfer(1'b1, OFS_COUNT, {16'h0, c});
         xfer(1'b1, OFS_FLAG_CLEAR, 32'h1f);
         xfer(1'b1, OFS_CAP_CTRL, cc);
         level <= ~level;
         wt(6);
         rc(OFS_CAP_VALUE, {16'h0, v});
         rc(OFS_COUNT, clr ? 32'h0 : {16'h0, c});
         rc(OFS_RAW_FLAGS, ld ? 32'h10 : 32'h0);
         chk(irq, ld);
         chk(cap_fn, fon);
      end
      xfer(1'b1, OFS_CAP_CTRL, 32'h0);
      $display("test capture done");
      xfer(1'b1, OFS_PULSE_CTRL, 32'h0010_0000);
      xfer(1'b1, OFS_MATCH0, 32'h2);
      xfer(1'b1, OFS_MATCH_CTRL, 32'h4);
      for (int a = 0; a < 4; a++) begin
         b = 1'($urandom);
         xfer(1'b1, OFS_RUN_CTRL, 32'h0);
         xfer(1'b1, OFS_COUNT, 32'h0);
         xfer(1'b1, OFS_OUT_MATCH, {26'h0, 2'(a), 3'h0, b});
         xfer(1'b1, OFS_RUN_CTRL, 32'h1);
         wait_halt;
         chk(pin_o, exp_ext(2'(a), b));
         rc(OFS_OUT_MATCH, {26'h0, 2'(a), 3'h0, exp_ext(2'(a), b)});
      end
      chk(pin_fn, 1'b1);
      $display("test external match done");
      d = 16'($urandom_range(5, 2));
      p = d + 16'($urandom_range(8, 3));
      xfer(1'b1, OFS_OUT_MATCH, 32'h10);
      xfer(1'b1, OFS_PULSE_CTRL, 32'h0010_0001);
      xfer(1'b1, OFS_MATCH0, {16'h0, d});
      xfer(1'b1, OFS_MATCH1, {16'h0, p});
      xfer(1'b1, OFS_MATCH_CTRL, 32'h10);
      xfer(1'b1, OFS_COUNT, 32'h0);
      xfer(1'b1, OFS_RUN_CTRL, 32'h1);
      wt(30);
      meas <= 1'b1;
      wt(4 * (p + 1));
      meas <= 1'b0;
      #1;
      chk(hi_cnt, 4 * (p - d + 1));
      $display("test pulse done");
      final_report;
   end
endmodule
`default_nettype wire
